// file: bdr_pkg.sv
// Constants and state type for the background debug register block.
package bdr_pkg;

  localparam logic [15:0] ADDR_CMD       = 16'hFF00;
  localparam logic [15:0] ADDR_STATUS    = 16'hFF01;
  localparam logic [15:0] ADDR_SHIFT_HI  = 16'hFF02;
  localparam logic [15:0] ADDR_SHIFT_LO  = 16'hFF03;
  localparam logic [15:0] ADDR_HOLD_HI   = 16'hFF04;
  localparam logic [15:0] ADDR_HOLD_LO   = 16'hFF05;
  localparam logic [15:0] ADDR_CCR_SAVE  = 16'hFF06;
  localparam logic [15:0] DBG_ROM_FIRST  = 16'hFF20;

  // Command register bit positions.
  localparam int CMD_HW_BIT      = 7;
  localparam int CMD_DATA_BIT    = 6;
  localparam int CMD_READ_BIT    = 5;
  localparam int CMD_BGREQ_BIT   = 4;
  localparam int CMD_WORD_BIT    = 3;
  localparam int CMD_MAPSEL_BIT  = 2;
  localparam int CMD_EXIT_LSB    = 3;
  localparam int CMD_TARGET_REGISTER_FIELD_LSB    = 0;

  // Status register bit positions.
  localparam int ST_PERMIT_BIT   = 7;
  localparam int ST_ACTIVE_BIT   = 6;
  localparam int ST_TAG_BIT      = 5;
  localparam int ST_SDV_BIT      = 4;
  localparam int ST_TRACE_BIT    = 3;

  localparam logic [7:0] BG_CMD_CODE     = 8'h90;
  localparam logic [1:0] EXIT_NONE       = 2'h0;
  localparam logic [1:0] EXIT_RESUME     = 2'h1;
  localparam logic [1:0] EXIT_STEP       = 2'h2;
  localparam logic [1:0] EXIT_TAG_RESUME = 2'h3;
  localparam logic [2:0] TARGET_REGISTER_FIELD_NEXT       = 3'h2;
  localparam logic [2:0] TARGET_REGISTER_FIELD_PC         = 3'h3;

  localparam logic [1:0] MODE_OFF        = 2'h0;
  localparam logic [1:0] MODE_SWI_DUAL   = 2'h1;
  localparam logic [1:0] MODE_BG_FULL    = 2'h2;
  localparam logic [1:0] MODE_BG_DUAL    = 2'h3;

  localparam logic [9:0] IDLE_CYCLES     = 10'h200;
  localparam logic [7:0] RESET_BYTE      = 8'h00;

  typedef struct packed {
    logic        pin_s1;
    logic        pin_s2;
    logic        pin_prev;
    logic [9:0]  idle_cnt;
    logic [7:0]  cmd;
    logic        permit;
    logic        active;
    logic        tag_en;
    logic        shifter_valid_flag;
    logic        trace;
    logic [15:0] shifter;
    logic [15:0] hold;
    logic [7:0]  condition_code_reg;
    logic [7:0]  rdata;
    logic        hit;
    logic        rom_sel;
    logic        resume;
    logic        step;
    logic        software_interrupt;
    logic        brk;
    logic        tag;
    logic        tag_swi;
  } bdr_state_t;

endpackage

// file: bdr_debug_regs.sv
// Background debug register set with breakpoint mode logic.
`timescale 1ns/1ps
module bdr_debug_regs (
  input  wire logic        ref_clk_in,
  input  wire logic        rst_in,
  input  wire logic        debug_serial_pin_in,
  input  wire logic [15:0] bus_addr_in,
  input  wire logic [7:0]  bus_wdata_in,
  input  wire logic        bus_wr_in,
  input  wire logic        bus_rd_in,
  input  wire logic        hw_cmd_valid_in,
  input  wire logic [7:0]  hw_cmd_in,
  input  wire logic        hw_shift_valid_in,
  input  wire logic [15:0] hw_shift_data_in,
  input  wire logic        hw_addr_valid_in,
  input  wire logic [15:0] hw_addr_in,
  input  wire logic        bg_enter_in,
  input  wire logic [7:0]  cpu_ccr_in,
  input  wire logic        cpu_cycle_in,
  input  wire logic        cpu_fetch_in,
  input  wire logic        cpu_read_in,
  input  wire logic [15:0] cpu_addr_in,
  input  wire logic [15:0] cpu_data_in,
  input  wire logic        tag_exec_in,
  input  wire logic        mode_select_hi_in,
  input  wire logic        mode_select_lo_in,
  input  wire logic        program_break_select_in,
  input  wire logic        data_compare_enable_in,
  input  wire logic        high_byte_mask_in,
  input  wire logic        low_byte_mask_in,
  input  wire logic        first_low_addr_enable_in,
  input  wire logic        second_low_addr_enable_in,
  input  wire logic [1:0]  rw_compare_value_in,
  input  wire logic [1:0]  rw_compare_enable_in,
  input  wire logic [15:0] bkpt_addr_in,
  input  wire logic [15:0] bkpt_data_in,
  output logic [7:0]       rd_data_out,
  output logic             rd_hit_out,
  output logic             rom_sel_out,
  output logic [7:0]       command_out,
  output logic [15:0]      shifter_out,
  output logic [7:0]       ccr_restore_out,
  output logic             debug_active_out,
  output logic             resume_out,
  output logic             single_step_out,
  output logic             software_interrupt_out,
  output logic             bdm_break_out,
  output logic             tag_fetch_out,
  output logic             tag_swi_out
);
  import bdr_pkg::*;

  bdr_state_t q;
  bdr_state_t d;

  logic       fall;
  logic       map_en;
  logic       cmd_ok;
  logic       fw_cmd;
  logic       hw_bg;
  logic [1:0] mode;
  logic       bp0;
  logic       bp1;
  logic       rw0;
  logic       rw1;
  logic       dmatch;
  logic       tag_hit;
  logic       brk_hit;
  logic       enter;

  // Upper byte always compared; the low byte only when its enable is set.
  function automatic logic addr_match(input logic [15:0] a, input logic [15:0] r,
                                      input logic low_en);
    addr_match = (a[15:8] == r[15:8]) && (!low_en || (a[7:0] == r[7:0]));
  endfunction

  function automatic logic reg_at(input logic en, input logic [15:0] a,
                                  input logic [15:0] off);
    reg_at = en && (a == off);
  endfunction

  assign fall   = q.pin_prev & ~q.pin_s2;
  assign map_en = q.active | (q.cmd[CMD_HW_BIT] & q.cmd[CMD_MAPSEL_BIT]);
  assign cmd_ok = hw_cmd_valid_in & ~q.tag_en;
  assign fw_cmd = cmd_ok & ~hw_cmd_in[CMD_HW_BIT] & q.active;
  assign hw_bg  = cmd_ok & (hw_cmd_in == BG_CMD_CODE);
  assign mode   = {mode_select_hi_in, mode_select_lo_in};

  assign bp0    = addr_match(cpu_addr_in, bkpt_addr_in, first_low_addr_enable_in);
  assign bp1    = data_compare_enable_in &
                  addr_match(cpu_addr_in, bkpt_data_in, second_low_addr_enable_in);
  assign rw0    = ~rw_compare_enable_in[0] | (cpu_read_in == rw_compare_value_in[0]);
  assign rw1    = ~rw_compare_enable_in[1] | (cpu_read_in == rw_compare_value_in[1]);
  assign dmatch = (high_byte_mask_in | (cpu_data_in[15:8] == bkpt_data_in[15:8])) &
                  (low_byte_mask_in | (cpu_data_in[7:0] == bkpt_data_in[7:0]));

  // Compare results per mode; the direction and mask controls that a mode ignores
  // simply never reach its term.
  always_comb begin
    tag_hit = 1'h0;
    brk_hit = 1'h0;
    case (mode)
      MODE_SWI_DUAL: begin
        tag_hit = cpu_fetch_in & (bp0 | bp1);
      end
      MODE_BG_FULL: begin
        if (program_break_select_in) begin
          tag_hit = cpu_fetch_in & bp0;
        end else begin
          brk_hit = cpu_cycle_in & bp0 & rw0 & (~data_compare_enable_in | dmatch);
        end
      end
      MODE_BG_DUAL: begin
        if (program_break_select_in) begin
          tag_hit = cpu_fetch_in & (bp0 | bp1);
        end else begin
          brk_hit = cpu_cycle_in & ((bp0 & rw0) | (bp1 & rw1));
        end
      end
      default: begin
        tag_hit = 1'h0;
        brk_hit = 1'h0;
      end
    endcase
    if (q.active) begin
      tag_hit = 1'h0;
      brk_hit = 1'h0;
    end
  end

  // The permit gate covers every entry path, breakpoints included, so a break taken
  // without permit cannot loop through the debug ROM.
  assign enter = ~q.active & q.permit &
                 (bg_enter_in | hw_bg | brk_hit | (tag_exec_in & (mode != MODE_SWI_DUAL)));

  always_comb begin
    d          = q;
    d.pin_s1   = debug_serial_pin_in;
    d.pin_s2   = q.pin_s1;
    d.pin_prev = q.pin_s2;
    d.resume   = 1'h0;
    d.step     = 1'h0;
    d.software_interrupt      = 1'h0;
    d.brk      = 1'h0;
    d.tag      = 1'h0;
    d.hit      = 1'h0;
    d.rdata    = RESET_BYTE;

    // Idle watchdog on host edges; it saturates so it clears once per idle spell.
    if (fall) begin
      d.idle_cnt = 10'h000;
    end else if (q.idle_cnt != IDLE_CYCLES) begin
      d.idle_cnt = q.idle_cnt + 10'h001;
    end
    if (!fall && (q.idle_cnt == IDLE_CYCLES - 10'h001)) begin
      d.cmd = RESET_BYTE;
    end

    // Register reads; the map gate keeps user memory visible otherwise.
    if (bus_rd_in && reg_at(map_en, bus_addr_in, bus_addr_in)) begin
      case (bus_addr_in)
        ADDR_CMD:      begin d.hit = 1'h1; d.rdata = q.cmd; end
        ADDR_STATUS:   begin
          d.hit = 1'h1;
          d.rdata[ST_PERMIT_BIT] = q.permit;
          d.rdata[ST_ACTIVE_BIT] = q.active;
          d.rdata[ST_TAG_BIT]    = q.tag_en;
          d.rdata[ST_SDV_BIT]    = q.shifter_valid_flag;
          d.rdata[ST_TRACE_BIT]  = q.trace;
        end
        ADDR_SHIFT_HI: begin d.hit = 1'h1; d.rdata = q.shifter[15:8]; end
        ADDR_SHIFT_LO: begin
          d.hit = 1'h1;
          d.rdata = q.shifter[7:0];
          d.shifter_valid_flag = 1'h0;
        end
        ADDR_HOLD_HI:  begin d.hit = 1'h1; d.rdata = q.hold[15:8]; end
        ADDR_HOLD_LO:  begin d.hit = 1'h1; d.rdata = q.hold[7:0]; end
        ADDR_CCR_SAVE: begin d.hit = 1'h1; d.rdata = q.condition_code_reg; end
        default:       begin d.hit = 1'h0; d.rdata = RESET_BYTE; end
      endcase
    end
    d.rom_sel = (bus_rd_in | bus_wr_in) & map_en & (bus_addr_in >= DBG_ROM_FIRST);

    // Bus writes first so hardware updates below override them in the same cycle.
    if (bus_wr_in) begin
      if (reg_at(map_en, bus_addr_in, ADDR_CMD)) begin
        d.cmd = bus_wdata_in;
      end
      if (reg_at(map_en, bus_addr_in, ADDR_STATUS)) begin
        d.permit = bus_wdata_in[ST_PERMIT_BIT];
        d.shifter_valid_flag    = bus_wdata_in[ST_SDV_BIT];
        d.trace  = bus_wdata_in[ST_TRACE_BIT];
      end
      if (reg_at(map_en, bus_addr_in, ADDR_SHIFT_HI)) begin
        d.shifter[15:8] = bus_wdata_in;
      end
      if (reg_at(map_en, bus_addr_in, ADDR_SHIFT_LO)) begin
        d.shifter[7:0] = bus_wdata_in;
      end
      if (reg_at(map_en, bus_addr_in, ADDR_CCR_SAVE)) begin
        d.condition_code_reg = bus_wdata_in;
      end
    end

    if (cmd_ok) begin
      d.cmd = hw_cmd_in;
      if (hw_cmd_in[CMD_HW_BIT] && (hw_cmd_in != BG_CMD_CODE)) begin
        d.cmd[CMD_BGREQ_BIT] = 1'h0;
      end
    end
    if (hw_shift_valid_in) begin
      d.shifter = hw_shift_data_in;
      d.shifter_valid_flag     = 1'h1;
    end
    if (hw_addr_valid_in) begin
      d.hold = hw_addr_in;
    end

    // Firmware exit field; register field 010 and 011 are carried in command_out.
    if (fw_cmd) begin
      case (hw_cmd_in[CMD_EXIT_LSB +: 2])
        EXIT_RESUME: begin
          d.active = 1'h0;
          d.resume = 1'h1;
        end
        EXIT_STEP: begin
          d.active = 1'h0;
          d.step   = 1'h1;
          d.trace  = 1'h1;
        end
        EXIT_TAG_RESUME: begin
          d.active = 1'h0;
          d.resume = 1'h1;
          d.tag_en = 1'h1;
        end
        default: begin
          d.active = q.active;
        end
      endcase
    end

    if (enter) begin
      d.active = 1'h1;
      d.tag_en = 1'h0;
      d.condition_code_reg    = cpu_ccr_in;
    end

    d.brk     = brk_hit & q.permit;
    d.tag     = tag_hit;
    d.tag_swi = (mode == MODE_SWI_DUAL);
    d.software_interrupt     = tag_exec_in & (mode == MODE_SWI_DUAL) & ~q.active;
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign rd_data_out            = q.rdata;
  assign rd_hit_out             = q.hit;
  assign rom_sel_out            = q.rom_sel;
  assign command_out            = q.cmd;
  assign shifter_out            = q.shifter;
  assign ccr_restore_out        = q.condition_code_reg;
  assign debug_active_out       = q.active;
  assign resume_out             = q.resume;
  assign single_step_out        = q.step;
  assign software_interrupt_out = q.software_interrupt;
  assign bdm_break_out          = q.brk;
  assign tag_fetch_out          = q.tag;
  assign tag_swi_out            = q.tag_swi;

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);

  sequence s_step_cmd;
    fw_cmd && (hw_cmd_in[CMD_EXIT_LSB +: 2] == EXIT_STEP);
  endsequence

  sequence s_step_done;
    q.trace && q.step && !q.active;
  endsequence

  a_idle_clear: assert property (
    (q.idle_cnt == IDLE_CYCLES - 10'h001) && !fall && !cmd_ok && !bus_wr_in
      |=> (q.cmd == RESET_BYTE))
    else $error("command register not cleared after idle spell");

  a_bgreq_only_bg: assert property (
    cmd_ok && hw_cmd_in[CMD_HW_BIT] && (hw_cmd_in != BG_CMD_CODE)
      |=> !q.cmd[CMD_BGREQ_BIT])
    else $error("background request flag set by another command");

  a_no_permit_entry: assert property (
    !q.active && !q.permit |=> !q.active)
    else $error("background entered without permit");

  a_entry_saves_ccr: assert property (
    enter |=> q.active && !q.tag_en && (q.condition_code_reg == $past(cpu_ccr_in)))
    else $error("entry did not save condition codes");

  a_tag_blocks_cmd: assert property (
    q.tag_en && hw_cmd_valid_in && !bus_wr_in && (q.idle_cnt != IDLE_CYCLES - 10'h001)
      |=> $stable(q.cmd))
    else $error("command taken while tagging enabled");

  a_step_trace: assert property (
    s_step_cmd |=> s_step_done)
    else $error("single step did not set trace");

  a_hold_hw_only: assert property (
    !hw_addr_valid_in |=> $stable(q.hold))
    else $error("address holding register changed without hardware");

  a_no_break_active: assert property (
    q.active |=> !q.brk && !q.tag && !q.software_interrupt)
    else $error("breakpoint raised while background active");

  a_unmapped_quiet: assert property (
    !map_en && bus_rd_in |=> !q.hit ##0 !q.rom_sel)
    else $error("debug addresses responded while unmapped");

  a_shift_valid: assert property (
    hw_shift_valid_in |=> q.shifter_valid_flag && (q.shifter == $past(hw_shift_data_in)))
    else $error("shifter valid not set on load");

  // A full-mode match with permit must both flag the break and enter background.
  a_full_break: assert property (
    (mode == MODE_BG_FULL) && !program_break_select_in && cpu_cycle_in && bp0 && rw0 &&
      (!data_compare_enable_in || dmatch) && !q.active && q.permit |=> q.brk && q.active)
    else $error("full mode break not taken");

  // Executed tags in interrupt mode raise an interrupt and never reach the debug ROM.
  a_swi_no_entry: assert property (
    tag_exec_in && (mode == MODE_SWI_DUAL) && !q.active && !bg_enter_in && !hw_bg
      |=> q.software_interrupt && !q.active)
    else $error("software interrupt mode entered background");

  a_resume_exit: assert property (
    fw_cmd && (hw_cmd_in[CMD_EXIT_LSB +: 2] == EXIT_RESUME) |=> q.resume && !q.active)
    else $error("resume command did not leave background");

endmodule // bdr_debug_regs

// file: bdr_host_model.sv
// Debug host model: drives the serial pin and the serial-side loads.
`timescale 1ns/1ps
module bdr_host_model (
  input  wire logic   ref_clk_in,
  output logic        serial_pin_out,
  output logic        cmd_valid_out,
  output logic [7:0]  cmd_out,
  output logic        load_valid_out,
  output logic [15:0] shift_out,
  output logic [15:0] addr_out
);
  initial begin
    serial_pin_out = 1'b1;
    cmd_valid_out  = 1'b0;
    cmd_out        = 8'hFF;
    load_valid_out = 1'b0;
    shift_out      = 16'hFFFF;
    addr_out       = 16'hFFFF;
  end

  // Every command opens with a falling edge, as a real frame would, then the pin
  // returns to its pulled-up idle level. Released data shows the inverse value.
  // Register writes during background reach the command, status, shifter and saved condition codes.
  task automatic send_cmd(input logic [7:0] code);
    serial_pin_out = 1'b0;
    @(posedge ref_clk_in); #1;
    serial_pin_out = 1'b1;
    cmd_out = code;
    cmd_valid_out = 1'b1;
    @(posedge ref_clk_in); #1;
    cmd_valid_out = 1'b0;
    cmd_out = ~code;
  endtask

  task automatic load(input logic [15:0] s, input logic [15:0] a);
    shift_out = s;
    addr_out = a;
    load_valid_out = 1'b1;
    @(posedge ref_clk_in); #1;
    load_valid_out = 1'b0;
    shift_out = ~s;
    addr_out = ~a;
  endtask
endmodule // bdr_host_model

// file: testbench.sv
// Self-checking testbench for the background debug register block.
`timescale 1ns/1ps
module testbench;
  import bdr_pkg::*;
  logic        clk, rst, pin, hcv, hsv, bus_wr, bus_rd, bg_enter, cyc, fetch, cread, texec;
  logic        pbs, dce, hbm, lbm, fle, sle, hit, rom, act, res, stp, software_interrupt, brk, tagf, tags;
  logic [1:0]  mode, rwv, rwe;
  logic [7:0]  hc, bus_wdata, condition_code_reg, rdata, cmd, ccr_r;
  logic [15:0] hsd, ha, bus_addr, caddr, cdata, baddr, bdata, shf;
  int          miscompares, comparisons;

  bdr_host_model u_host (.ref_clk_in(clk), .serial_pin_out(pin), .cmd_valid_out(hcv),
    .cmd_out(hc), .load_valid_out(hsv), .shift_out(hsd), .addr_out(ha));

  bdr_debug_regs u_dut (.ref_clk_in(clk), .rst_in(rst), .debug_serial_pin_in(pin),
    .bus_addr_in(bus_addr), .bus_wdata_in(bus_wdata), .bus_wr_in(bus_wr),
    .bus_rd_in(bus_rd), .hw_cmd_valid_in(hcv), .hw_cmd_in(hc), .hw_shift_valid_in(hsv),
    .hw_shift_data_in(hsd), .hw_addr_valid_in(hsv), .hw_addr_in(ha),
    .bg_enter_in(bg_enter), .cpu_ccr_in(condition_code_reg), .cpu_cycle_in(cyc), .cpu_fetch_in(fetch),
    .cpu_read_in(cread), .cpu_addr_in(caddr), .cpu_data_in(cdata), .tag_exec_in(texec),
    .mode_select_hi_in(mode[1]), .mode_select_lo_in(mode[0]),
    .program_break_select_in(pbs), .data_compare_enable_in(dce),
    .high_byte_mask_in(hbm), .low_byte_mask_in(lbm), .first_low_addr_enable_in(fle),
    .second_low_addr_enable_in(sle), .rw_compare_value_in(rwv),
    .rw_compare_enable_in(rwe), .bkpt_addr_in(baddr), .bkpt_data_in(bdata),
    .rd_data_out(rdata), .rd_hit_out(hit), .rom_sel_out(rom), .command_out(cmd),
    .shifter_out(shf), .ccr_restore_out(ccr_r), .debug_active_out(act),
    .resume_out(res), .single_step_out(stp), .software_interrupt_out(software_interrupt),
    .bdm_break_out(brk), .tag_fetch_out(tagf), .tag_swi_out(tags));

  always #25 clk = ~clk;

  task automatic finish_test();
    if (miscompares == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] e, input logic h);
    bus_addr = a;
    bus_rd = 1'b1;
    @(posedge clk); #1;
    bus_rd = 1'b0;
    chk("rd_hit", 16'(h), 16'(hit));
    chk("rd_data", 16'(e), 16'(rdata));
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    bus_addr = a;
    bus_wdata = d;
    bus_wr = 1'b1;
    @(posedge clk); #1;
    bus_wr = 1'b0;
  endtask

  // One valid CPU cycle; the breakpoint answer is looked at one cycle later.
  task automatic cpu(input logic [15:0] a, input logic f, input logic eb, input logic et);
    caddr = a;
    fetch = f;
    cyc = 1'b1;
    @(posedge clk); #1;
    cyc = 1'b0;
    chk("brk", 16'(eb), 16'(brk));
    chk("tag_fetch", 16'(et), 16'(tagf));
  endtask

  task automatic t_map();
    rd(16'hFF20, 8'h00, 1'b0);
    chk("rom_sel", 16'h0000, 16'(rom));
    rd(ADDR_STATUS, 8'h00, 1'b0);
    u_host.send_cmd(8'hE4);
    rd(ADDR_STATUS, 8'h00, 1'b1);
    wr(ADDR_STATUS, 8'h80);
    rd(ADDR_STATUS, 8'h80, 1'b1);
    rd(16'hFF07, 8'h00, 1'b0);
    rd(16'hFF20, 8'h00, 1'b0);
    chk("rom_sel", 16'h0001, 16'(rom));
  endtask

  task automatic t_regs();
    condition_code_reg = 8'hA5;
    u_host.send_cmd(BG_CMD_CODE);
    chk("command", 16'h0090, 16'(cmd));
    chk("active", 16'h0001, 16'(act));
    chk("ccr_save", 16'h00A5, 16'(ccr_r));
    rd(ADDR_STATUS, 8'hC0, 1'b1);
    wr(ADDR_CCR_SAVE, 8'h3C);
    chk("ccr_save", 16'h003C, 16'(ccr_r));
    rd(ADDR_CCR_SAVE, 8'h3C, 1'b1);
    u_host.load(16'h5AC3, 16'h1234);
    rd(ADDR_STATUS, 8'hD0, 1'b1);
    rd(ADDR_SHIFT_HI, 8'h5A, 1'b1);
    rd(ADDR_SHIFT_LO, 8'hC3, 1'b1);
    rd(ADDR_STATUS, 8'hC0, 1'b1);
    u_host.send_cmd(8'hD0);
    chk("command", 16'h00C0, 16'(cmd));
  endtask

  task automatic t_exits();
    u_host.send_cmd(8'h62);
    chk("command", 16'h0062, 16'(cmd));
    u_host.send_cmd(8'h08);
    chk("resume", 16'h0001, 16'(res));
    chk("active", 16'h0000, 16'(act));
    u_host.send_cmd(BG_CMD_CODE);
    u_host.send_cmd(8'h10);
    chk("step", 16'h0001, 16'(stp));
    u_host.send_cmd(8'hE4);
    rd(ADDR_STATUS, 8'h88, 1'b1);
    // Outside background the host may write the shifter and try the address register.
    wr(ADDR_SHIFT_HI, 8'h77);
    chk("shifter", 16'h77C3, shf);
    wr(ADDR_HOLD_HI, 8'hFF);
    rd(ADDR_HOLD_HI, 8'h12, 1'b1);
    rd(ADDR_HOLD_LO, 8'h34, 1'b1);
    u_host.send_cmd(BG_CMD_CODE);
    u_host.send_cmd(8'h18);
    chk("resume", 16'h0001, 16'(res));
    u_host.send_cmd(BG_CMD_CODE);
    chk("command", 16'h0018, 16'(cmd));
    chk("active", 16'h0000, 16'(act));
    bg_enter = 1'b1;
    @(posedge clk); #1;
    bg_enter = 1'b0;
    rd(ADDR_STATUS, 8'hC8, 1'b1);
  endtask

  task automatic t_bkpt();
    u_host.send_cmd(8'h08);
    mode = MODE_BG_FULL;
    baddr = 16'h1234;
    cpu(16'h1299, 1'b0, 1'b0, 1'b0);
    fle = 1'b0;
    cpu(16'h1299, 1'b0, 1'b1, 1'b0);
    cpu(16'h1299, 1'b0, 1'b0, 1'b0);
    u_host.send_cmd(8'h08);
    pbs = 1'b1;
    cpu(16'h1200, 1'b1, 1'b0, 1'b1);
    mode = MODE_OFF;
    cpu(16'h1200, 1'b1, 1'b0, 1'b0);
    mode = MODE_SWI_DUAL;
    cpu(16'h4000, 1'b1, 1'b0, 1'b0);
    dce = 1'b1;
    cpu(16'h4000, 1'b1, 1'b0, 1'b1);
    texec = 1'b1;
    @(posedge clk); #1;
    texec = 1'b0;
    chk("swi", 16'h0001, 16'(software_interrupt));
    chk("tag_swi", 16'h0001, 16'(tags));
    mode = MODE_BG_DUAL;
    pbs = 1'b0;
    cread = 1'b0;
    cpu(16'h4000, 1'b0, 1'b0, 1'b0);
    cread = 1'b1;
    cpu(16'h4000, 1'b0, 1'b1, 1'b0);
  endtask

  // Data compare, byte masks, direction and second range in the two background modes.
  task automatic t_data();
    u_host.send_cmd(8'h08);
    mode = MODE_BG_FULL;
    bdata = 16'hBEEF;
    cdata = 16'hBEEE;
    cpu(16'h1299, 1'b0, 1'b0, 1'b0);
    chk("tag_swi", 16'h0000, 16'(tags));
    lbm = 1'b1;
    cpu(16'h1299, 1'b0, 1'b1, 1'b0);
    u_host.send_cmd(8'h08);
    {hbm, lbm, cdata} = {2'h2, 16'h00EF};
    rwe = 2'h3;
    rwv = 2'h0;
    cpu(16'h1299, 1'b0, 1'b0, 1'b0);
    cread = 1'b0;
    cpu(16'h1299, 1'b0, 1'b1, 1'b0);
    u_host.send_cmd(8'h08);
    mode = MODE_BG_DUAL;
    {sle, rwe, bdata} = {3'h0, 16'h4000};
    cpu(16'h40AA, 1'b0, 1'b1, 1'b0);
  endtask

  // The synced falling edge lands one cycle after the command; the clear follows 512 later.
  task automatic t_idle();
    u_host.send_cmd(8'h08);
    u_host.send_cmd(8'hE4);
    wr(ADDR_STATUS, 8'h00);
    u_host.send_cmd(BG_CMD_CODE);
    chk("active", 16'h0000, 16'(act));
    repeat (512) @(posedge clk);
    #1;
    chk("command", 16'h0090, 16'(cmd));
    @(posedge clk);
    #1;
    chk("command", 16'h0000, 16'(cmd));
  endtask

  initial begin
    {clk, bus_wr, bus_rd, bg_enter, cyc, fetch, cread, texec, pbs, dce, hbm, lbm} = '0;
    {rst, fle, sle} = 3'h7;
    {mode, bus_wdata, condition_code_reg, bus_addr, caddr, cdata, baddr} = '0;
    bdata = 16'h4000;
    rwv = 2'h2;
    rwe = 2'h2;
    miscompares = 0;
    comparisons = 0;
    repeat (6) @(posedge clk);
    #1;
    rst = 1'b0;
    t_map();
    t_regs();
    t_exits();
    t_bkpt();
    t_data();
    t_idle();
    finish_test();
  end

  initial begin
    #(3000 * 50);
    miscompares++;
    finish_test();
  end
endmodule // testbench
